/* rtl/prog_mem_pkg.sv */
// Contract
// - store holds 2048 sixteen-bit words
// - fetch restarts at word zero after reset
// - table address from both pointer registers, or last page plus low pointer
// - low program byte goes to operand register
// - upper word part loads table high latch
// - unused latch bits read as zero
// - latch is read-only, writes ignored
// - table reads take two instruction cycles
// - full read uses high page, low offset
// - programming port: serial data plus external clock
// - debug port: serial data plus clock input
package prog_mem_pkg;
  localparam int ADDR_W = 11;
  localparam int WORD_W = 16;
  localparam int DEPTH = 2048;
  localparam int HIGH_W = WORD_W - 8;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam int TABLE_CYCLES = 2;
  localparam int SYNC_STAGES = 3;
  localparam int SER_CNT_W = 5;

  typedef struct packed {
    logic       valid;
    logic       lastPage;
    logic [7:0] destAddr;
  } table_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] destAddr;
    logic [7:0] lowByte;
  } table_wr_t;

  typedef enum logic [2:0] {
    S_FETCH = 3'b001,
    S_TABLE = 3'b010,
    S_DONE  = 3'b100
  } fetch_state_t;
endpackage

/* rtl/program_memory_table_reader.sv */
`timescale 1ns/10ps
`default_nettype none
module program_memory_table_reader
  import prog_mem_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              fetchAdvance,
  input  wire logic [ADDR_W-1:0] jumpAddr,
  input  wire logic              jumpLoad,
  input  wire table_req_t        tableReq,
  input  wire logic [7:0]        tablePtrLow,
  input  wire logic [2:0]        tablePtrHigh,
  input  wire logic              latchWriteAttempt,
  input  wire logic              prog_serial_clock,
  input  wire logic              prog_serial_data_in,
  output logic                   prog_serial_data_out,
  output logic                   prog_serial_data_oe,
  input  wire logic              debug_serial_clock,
  input  wire logic              debug_serial_data_in,
  output logic                   debug_serial_data_out,
  output logic                   debug_serial_data_oe,
  output logic [ADDR_W-1:0]      pcOut,
  output logic [WORD_W-1:0]      instrWord,
  output logic                   instrValid,
  output logic                   tableBusy,
  output table_wr_t              tableWrite,
  output logic [7:0]             table_high_latch
);
  //////////////////////////////////////////////////////////////////////////////
  // program store
  logic [WORD_W-1:0] progStore [DEPTH];
  logic [ADDR_W-1:0] pcReg;
  logic [ADDR_W-1:0] tableAddrReg;
  logic [7:0]        destReg;
  fetch_state_t      stateReg;
  logic [WORD_W-1:0] progWordIn;
  logic [ADDR_W-1:0] progAddrIn;
  logic              progWriteStb;

  function automatic logic [ADDR_W-1:0] table_addr(input logic lastPg,
                                                   input logic [2:0] hi,
                                                   input logic [7:0] lo);
    table_addr = lastPg ? {LAST_PAGE, lo} : {hi, lo};
  endfunction

  always_ff @(posedge clk_sys) begin
    if (progWriteStb) begin
      progStore[progAddrIn] <= progWordIn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fetch and table sequencing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stateReg     <= S_FETCH;
      pcReg        <= RESET_VECTOR;
      tableAddrReg <= '0;
      destReg      <= 8'h00;
    end else begin
      case (stateReg)
        S_FETCH: begin
          if (tableReq.valid) begin
            stateReg     <= S_TABLE;
            tableAddrReg <= table_addr(tableReq.lastPage, tablePtrHigh, tablePtrLow);
            destReg      <= tableReq.destAddr;
          end else if (jumpLoad) begin
            pcReg <= jumpAddr;
          end else if (fetchAdvance) begin
            pcReg <= pcReg + 11'h001;
          end
        end
        S_TABLE: stateReg <= S_DONE;
        S_DONE:  stateReg <= S_FETCH;
        default: stateReg <= S_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pcOut      <= RESET_VECTOR;
      instrWord  <= 16'h0000;
      instrValid <= 1'b0;
      tableBusy  <= 1'b0;
    end else begin
      pcOut      <= pcReg;
      instrWord  <= progStore[pcReg];
      instrValid <= (stateReg == S_FETCH) && !tableReq.valid;
      tableBusy  <= tableReq.valid || (stateReg == S_TABLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // table result: low byte to operand, high byte to latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tableWrite       <= '0;
      table_high_latch <= 8'h00;
    end else begin
      tableWrite.valid <= 1'b0;
      if (stateReg == S_TABLE) begin
        tableWrite.valid    <= 1'b1;
        tableWrite.destAddr <= destReg;
        tableWrite.lowByte  <= progStore[tableAddrReg][7:0];
        table_high_latch    <= 8'(progStore[tableAddrReg][WORD_W-1:8]);
      end
      // latchWriteAttempt deliberately has no effect
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial ports: three-stage sync, shift when stages 2 and 3 show a rise
  logic [SYNC_STAGES-1:0] pClkSync, pDatSync, dClkSync, dDatSync;
  logic [WORD_W+ADDR_W-1:0] progShift;
  logic [SER_CNT_W-1:0]     progCnt;
  logic [WORD_W-1:0]        dbgShift;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pClkSync <= '0;
      pDatSync <= '0;
      dClkSync <= '0;
      dDatSync <= '0;
    end else begin
      pClkSync <= {pClkSync[1:0], prog_serial_clock};
      pDatSync <= {pDatSync[1:0], prog_serial_data_in};
      dClkSync <= {dClkSync[1:0], debug_serial_clock};
      dDatSync <= {dDatSync[1:0], debug_serial_data_in};
    end
  end

  // a clock rise counts once stages two and three agree high
  function automatic logic rise_seen(input logic [1:0] stages,
                                     input logic       level);
    rise_seen = (stages == 2'h3) && !level;
  endfunction

  logic pClkLevel;
  logic dClkLevel;
  logic progClkRise;
  logic dbgClkRise;

  assign progClkRise = rise_seen(pClkSync[2:1], pClkLevel);
  assign dbgClkRise  = rise_seen(dClkSync[2:1], dClkLevel);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pClkLevel <= 1'b0;
      dClkLevel <= 1'b0;
    end else begin
      if (pClkSync[2] == pClkSync[1]) begin
        pClkLevel <= pClkSync[2];
      end
      if (dClkSync[2] == dClkSync[1]) begin
        dClkLevel <= dClkSync[2];
      end
    end
  end

  // programmer clocks in 11-bit address then 16-bit word, then it is written
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      progShift            <= '0;
      progCnt              <= '0;
      progWriteStb         <= 1'b0;
      progWordIn           <= '0;
      progAddrIn           <= '0;
      prog_serial_data_out <= 1'b0;
      prog_serial_data_oe  <= 1'b0;
    end else begin
      progWriteStb <= 1'b0;
      prog_serial_data_oe <= 1'b0;
      if (progClkRise) begin
        progShift <= {progShift[WORD_W+ADDR_W-2:0], pDatSync[2]};
        if (progCnt == 5'(WORD_W + ADDR_W - 1)) begin
          progCnt      <= '0;
          progAddrIn   <= progShift[WORD_W+ADDR_W-2:WORD_W-1];
          progWordIn   <= {progShift[WORD_W-2:0], pDatSync[2]};
          progWriteStb <= 1'b1;
        end else begin
          progCnt <= progCnt + 5'h01;
        end
      end
      prog_serial_data_out <= progShift[WORD_W+ADDR_W-1];
    end
  end

  // debug port returns current program counter word serially
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dbgShift              <= '0;
      debug_serial_data_out <= 1'b0;
      debug_serial_data_oe  <= 1'b0;
    end else begin
      if (dbgClkRise) begin
        if (dDatSync[2]) begin
          dbgShift <= {5'h00, pcReg};
        end else begin
          dbgShift <= {dbgShift[WORD_W-2:0], 1'b0};
        end
      end
      debug_serial_data_out <= dbgShift[WORD_W-1];
      debug_serial_data_oe  <= dClkSync[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_vector_fetch: assert property (@(posedge clk_sys)
    $rose(rstn) |-> pcReg == RESET_VECTOR) else $error("pc not at reset vector");
  a_table_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stateReg == S_FETCH && tableReq.valid) |=> stateReg == S_TABLE ##1 stateReg == S_DONE)
    else $error("table read not two cycles");
  a_table_low_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stateReg == S_TABLE) |=> tableWrite.valid && tableWrite.destAddr == $past(destReg))
    else $error("low byte write missing");
  a_latch_read_only: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stateReg != S_TABLE) |=> $stable(table_high_latch)) else $error("latch changed");
  a_latch_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(stateReg == S_TABLE) |-> table_high_latch == 8'(progStore[$past(tableAddrReg)] >> 8))
    else $error("latch content wrong");
  a_last_page_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stateReg == S_FETCH && tableReq.valid && tableReq.lastPage)
    |=> tableAddrReg[10:8] == LAST_PAGE) else $error("last page addr wrong");
  a_full_table_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stateReg == S_FETCH && tableReq.valid && !tableReq.lastPage)
    |=> tableAddrReg == {$past(tablePtrHigh), $past(tablePtrLow)}) else $error("addr wrong");
  a_pc_holds_table: assert property (@(posedge clk_sys) disable iff (!rstn)
    (stateReg != S_FETCH) |=> $stable(pcReg)) else $error("pc moved in table read");
  a_latch_write_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
    (latchWriteAttempt && stateReg != S_TABLE) |=> $stable(table_high_latch))
    else $error("latch took a write");
  a_prog_word_stored: assert property (@(posedge clk_sys) disable iff (!rstn)
    progWriteStb |=> progStore[$past(progAddrIn)] == $past(progWordIn))
    else $error("programmed word not stored");
  a_debug_pc_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    (dbgClkRise && dDatSync[2]) |=> dbgShift == {5'h00, $past(pcReg)})
    else $error("debug pc load wrong");
  c_table_read: cover property (@(posedge clk_sys) tableWrite.valid);
  c_last_page: cover property (@(posedge clk_sys) tableReq.valid && tableReq.lastPage);
  c_prog_write: cover property (@(posedge clk_sys) progWriteStb);
  c_debug_load: cover property (@(posedge clk_sys) dbgClkRise && dDatSync[2]);
  c_jump_fetch: cover property (@(posedge clk_sys) jumpLoad && stateReg == S_FETCH);
endmodule
`default_nettype wire

/* tb/prog_writer.sv */
`timescale 1ns/10ps
`default_nettype none
module prog_writer (
  input  wire logic clk_sys,
  input  wire logic dbgReturn,
  output logic      progClk,
  output logic      progData,
  output logic      dbgClk,
  output logic      dbgData
);
  initial begin
    progClk = 1'b0;
    progData = 1'b0;
    dbgClk = 1'b0;
    dbgData = 1'b0;
  end
  // address then word, msb first, clock idles low between frames
  task automatic send(input logic [10:0] a, input logic [15:0] w);
    logic [26:0] f;
    f = {a, w};
    @(posedge clk_sys);
    for (int i = 26; i >= 0; i--) begin
      progData <= f[i];
      repeat (4) @(posedge clk_sys);
      progClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      progClk <= 1'b0;
    end
    progData <= ~f[0];
    repeat (8) @(posedge clk_sys);
  endtask
  // debug adapter: first pulse with data high loads pc, then msb first
  task automatic dbg_read(output logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys);
      dbgData <= (i == 15);
      repeat (4) @(posedge clk_sys);
      dbgClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      dbgClk <= 1'b0;
      repeat (3) @(negedge clk_sys);
      v[i] = dbgReturn;
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import prog_mem_pkg::*;
  localparam logic [10:0] ADDRS [5] = '{11'h706, 11'h705, 11'h0A5, 11'h7FF, 11'h000};
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic              latchWriteAttempt = 1'b0;
  logic [7:0]        tablePtrLow = 8'h00;
  logic [2:0]        tablePtrHigh = 3'h0;
  table_req_t        tableReq = '0;
  table_wr_t         tableWrite;
  logic              progClk, progData, tableBusy;
  logic              fetchAdvance = 1'b0;
  logic              jumpLoad = 1'b0;
  logic [ADDR_W-1:0] jumpAddr = '0;
  logic [15:0]       instrWord;
  logic              instrValid, progOe, dbgClk, dbgData, dbgReturn, dbgOe;
  logic [15:0]       dv;
  logic [ADDR_W-1:0] pcOut;
  logic [7:0]        table_high_latch;
  logic [23:0]       expQ [$];
  logic [23:0]       e;
  logic [15:0]       mem [0:2047];
  logic [15:0]       seed = 16'h0046;
  int                mismatches = 0;
  int                n_tests = 0;
  int                cycles = 0;
  always #25 clk_sys = ~clk_sys;
  prog_writer pw (.clk_sys(clk_sys), .dbgReturn(dbgReturn), .progClk(progClk),
                  .progData(progData), .dbgClk(dbgClk), .dbgData(dbgData));
  program_memory_table_reader dut (
    .clk_sys(clk_sys), .rstn(rstn), .fetchAdvance(fetchAdvance), .jumpAddr(jumpAddr),
    .jumpLoad(jumpLoad), .tableReq(tableReq), .tablePtrLow(tablePtrLow),
    .tablePtrHigh(tablePtrHigh), .latchWriteAttempt(latchWriteAttempt),
    .prog_serial_clock(progClk), .prog_serial_data_in(progData),
    .prog_serial_data_out(), .prog_serial_data_oe(progOe), .debug_serial_clock(dbgClk),
    .debug_serial_data_in(dbgData), .debug_serial_data_out(dbgReturn),
    .debug_serial_data_oe(dbgOe), .pcOut(pcOut), .instrWord(instrWord),
    .instrValid(instrValid), .tableBusy(tableBusy),
    .tableWrite(tableWrite), .table_high_latch(table_high_latch));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (!ok) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // dup holds the request into the busy cycle, which must be refused
  task automatic tread(input logic lp, input logic [2:0] hi, input logic [7:0] lo,
                       input logic dup);
    logic [10:0] a;
    a = lp ? {LAST_PAGE, lo} : {hi, lo};
    expQ.push_back({seed[7:0], mem[a]});
    @(posedge clk_sys);
    tableReq <= '{1'b1, lp, seed[7:0]};
    tablePtrHigh <= hi;
    tablePtrLow <= lo;
    @(posedge clk_sys);
    tableReq.valid <= dup;
    @(negedge clk_sys);
    check(tableBusy === 1'b1 && tableWrite.valid === 1'b0, "busy");
    @(posedge clk_sys);
    tableReq.valid <= 1'b0;
    @(negedge clk_sys);
    check(tableWrite.valid === 1'b1, "latency");
    seed = lfsr(seed);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    if (rstn && tableWrite.valid === 1'b1) begin
      if (expQ.size() == 0) check(1'b0, "unexpected write");
      else begin
        e = expQ.pop_front();
        check(tableWrite.destAddr === e[23:16], "dest");
        check(tableWrite.lowByte === e[7:0], "low byte");
        check(table_high_latch === e[15:8], "latch");
      end
    end
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    check(pcOut === RESET_VECTOR, "reset pc");
    foreach (ADDRS[i]) begin
      mem[ADDRS[i]] = seed;
      pw.send(ADDRS[i], seed);
      seed = lfsr(seed);
    end
    tread(1'b0, 3'h7, 8'h06, 1'b0);
    tread(1'b1, 3'h0, 8'h05, 1'b1);
    tread(1'b0, 3'h0, 8'hA5, 1'b0);
    tread(1'b1, 3'h2, 8'hFF, 1'b0);
    @(posedge clk_sys);
    latchWriteAttempt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    latchWriteAttempt <= 1'b0;
    @(negedge clk_sys);
    check(table_high_latch === mem[11'h7FF][15:8], "latch written");
    check(expQ.size() == 0, "missing write");
    // mid-run reset: fetch restarts at the vector, store contents survive
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(pcOut === RESET_VECTOR && instrWord === mem[RESET_VECTOR] && instrValid === 1'b1,
          "vector fetch");
    @(posedge clk_sys);
    jumpAddr <= ADDRS[2];
    jumpLoad <= 1'b1;
    @(posedge clk_sys);
    jumpLoad <= 1'b0;
    fetchAdvance <= 1'b1;
    @(posedge clk_sys);
    fetchAdvance <= 1'b0;
    @(negedge clk_sys);
    check(pcOut === ADDRS[2] && instrWord === mem[ADDRS[2]], "jump fetch");
    @(negedge clk_sys);
    check(pcOut === ADDRS[2] + 11'h001, "advance");
    pw.dbg_read(dv);
    check(dv === {5'h00, ADDRS[2] + 11'h001}, "debug pc");
    repeat (4) @(negedge clk_sys);
    check(dbgOe === 1'b0 && progOe === 1'b0, "pins released");
    complete_run();
  end
endmodule
`default_nettype wire
